// ---- pvdc_host_model.sv ----
// Parallel register-port host model issuing register writes and reads
`timescale 1ns/1ps
`default_nettype none

module pvdc_host_model (
  input  wire logic       i_clk,
  input  wire logic [7:0] i_rdata,
  output var  logic       o_wr_en,
  output var  logic [7:0] o_addr,
  output var  logic [7:0] o_wdata
);
  initial begin
    o_wr_en = 1'b0;
    o_addr  = 8'h00;
    o_wdata = 8'h00;
  end

  // One byte write, strobe high for one cycle
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge i_clk);
    o_wr_en = 1'b1;
    o_addr  = a;
    o_wdata = (a == 8'h18) ? {1'b0, d[6:0]} : d;
    @(negedge i_clk);
    o_wr_en = 1'b0;
    o_wdata = ~o_wdata;
  endtask

  // Registered read, one cycle latency
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge i_clk);
    o_addr = a;
    @(negedge i_clk);
    d = i_rdata;
  endtask
endmodule // pvdc_host_model
`default_nettype wire

// ---- pvdc_lock_pin_mux.sv ----
// Lock indicator pin source selection
`timescale 1ns/1ps
`default_nettype none

module pvdc_lock_pin_mux (
  input  wire logic       i_clk,
  input  wire logic       i_rst_n,
  input  wire logic       i_ce,
  input  wire logic       i_test_en,
  input  wire logic [1:0] i_test_sel,
  input  wire logic       i_lock_status,
  input  wire logic       i_crystal_osc_output,
  input  wire logic       i_pump_up_half,
  input  wire logic       i_compare_ref_half,
  input  wire logic       i_compare_fb_half,
  output var  logic       o_lock_pin
);

  logic test_sig;

  // Test source selection
  always_comb begin
    case (pvdc_pkg::pvdc_test_sel_t'(i_test_sel))
      pvdc_pkg::PVDC_TEST_CRYSTAL: test_sig = i_crystal_osc_output;
      pvdc_pkg::PVDC_TEST_PUMP_UP: test_sig = i_pump_up_half;
      pvdc_pkg::PVDC_TEST_REF:     test_sig = i_compare_ref_half;
      pvdc_pkg::PVDC_TEST_FB:      test_sig = i_compare_fb_half;
      default:                     test_sig = 1'b0;
    endcase
  end

  // Lock status or test signal onto the pin
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_lock_pin <= 1'b0;
    end else if (i_ce) begin
      o_lock_pin <= i_test_en ? test_sig : i_lock_status;
    end
  end

endmodule // pvdc_lock_pin_mux

`default_nettype wire

// ---- pvdc_pkg.sv ----
// Constants for the PLL, VCO and divider control register bank
package pvdc_pkg;

  // Register window
  localparam logic [7:0] BASE_ADDR  = 8'h0e;
  localparam int         REG_COUNT  = 12;
  localparam logic [7:0] LAST_ADDR  = 8'h19;

  // Register offsets
  localparam logic [7:0] VCO_CONTROL           = 8'h0e;
  localparam logic [7:0] VCO_LEVEL             = 8'h0f;
  localparam logic [7:0] VCO_BAND              = 8'h10;
  localparam logic [7:0] SPARE_A               = 8'h11;
  localparam logic [7:0] FEEDBACK_DIV_HIGH     = 8'h12;
  localparam logic [7:0] FEEDBACK_DIV_MID      = 8'h13;
  localparam logic [7:0] FEEDBACK_DIV_LOW_CTRL = 8'h14;
  localparam logic [7:0] FIRST_OUT_DIV_HIGH    = 8'h15;
  localparam logic [7:0] OUT_DIV_SPLIT         = 8'h16;
  localparam logic [7:0] SECOND_OUT_DIV_TEST   = 8'h17;
  localparam logic [7:0] PRESCALE_SELECT       = 8'h18;
  localparam logic [7:0] SPARE_B               = 8'h19;

  // Array indices (offset minus base)
  localparam int IDX_VCO_CONTROL = 0;
  localparam int IDX_VCO_LEVEL   = 1;
  localparam int IDX_VCO_BAND    = 2;
  localparam int IDX_FB_HIGH     = 4;
  localparam int IDX_FB_MID      = 5;
  localparam int IDX_FB_LOW_CTRL = 6;
  localparam int IDX_P1_HIGH     = 7;
  localparam int IDX_DIV_SPLIT   = 8;
  localparam int IDX_P2_TEST     = 9;
  localparam int IDX_PRESCALE    = 10;

  // Reset values, in offset order
  localparam logic [7:0] RST_VAL [REG_COUNT] = '{
    8'h70, 8'h80, 8'h80, 8'h00, 8'h80, 8'h00,
    8'h00, 8'h20, 8'h00, 8'h00, 8'h20, 8'h00
  };

  // Writable bits, in offset order; all other bits read zero
  localparam logic [7:0] WR_MASK [REG_COUNT] = '{
    8'hff, 8'hfc, 8'hfe, 8'h00, 8'hff, 8'hff,
    8'hfd, 8'hff, 8'hff, 8'hfe, 8'h60, 8'h00
  };

  // vco_control fields
  localparam int CAL_START_BIT   = 7;
  localparam int AMP_LOOP_BIT    = 6;
  localparam int AMP_THR_MSB     = 5;
  localparam int AMP_THR_LSB     = 3;
  localparam int CAL_REG_CTL_BIT = 2;
  localparam int SUPPLY_BOOST_BIT = 1;
  localparam int BAND_REG_CTL_BIT = 0;

  // vco_level and vco_band fields
  localparam int LEVEL_MSB = 7;
  localparam int LEVEL_LSB = 2;
  localparam int BAND_MSB  = 7;
  localparam int BAND_LSB  = 1;

  // feedback_div_low_ctrl fields
  localparam int FB_NIB_MSB       = 7;
  localparam int FB_NIB_LSB       = 4;
  localparam int FB_REG_CTL_BIT   = 3;
  localparam int OUT_REG_CTL_BIT  = 2;
  localparam int PLL_RESET_BIT    = 0;

  // out_div_split fields
  localparam int P1_LOW_MSB = 7;
  localparam int P1_LOW_LSB = 6;
  localparam int P2_HIGH_MSB = 5;
  localparam int P2_HIGH_LSB = 0;

  // second_out_div_test fields
  localparam int P2_LOW_MSB   = 7;
  localparam int P2_LOW_LSB   = 4;
  localparam int TEST_EN_BIT  = 3;
  localparam int TEST_SEL_MSB = 2;
  localparam int TEST_SEL_LSB = 1;

  // prescale_select fields
  localparam int PRE_MSB = 6;
  localparam int PRE_LSB = 5;

  // Widths
  localparam int FB_DIV_W  = 20;
  localparam int OUT_DIV_W = 11;

  // Prescaler codes
  localparam logic [1:0] PRE_DIV5 = 2'h1;
  localparam logic [1:0] PRE_DIV6 = 2'h2;

  // Test multiplexer selections
  typedef enum logic [1:0] {
    PVDC_TEST_CRYSTAL = 2'h0,
    PVDC_TEST_PUMP_UP = 2'h1,
    PVDC_TEST_REF     = 2'h2,
    PVDC_TEST_FB      = 2'h3
  } pvdc_test_sel_t;

endpackage : pvdc_pkg

// ---- pvdc_regs.sv ----
// PLL, VCO and divider control register bank with effective-value outputs
`timescale 1ns/1ps
`default_nettype none

module pvdc_regs (
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  input  wire logic        i_ce,
  // Register access port
  input  wire logic        i_wr_en,
  input  wire logic [7:0]  i_addr,
  input  wire logic [7:0]  i_wdata,
  output var  logic [7:0]  o_rdata,
  // Pin-programmed values
  input  wire logic [19:0] i_pin_fb_div,
  input  wire logic [1:0]  i_pin_prescale,
  input  wire logic [10:0] i_pin_first_div,
  input  wire logic [10:0] i_pin_second_div,
  // Lock and test sources
  input  wire logic        i_lock_det_pd,
  input  wire logic        i_pll_locked,
  input  wire logic        i_crystal_osc_output,
  input  wire logic        i_pump_up_half,
  input  wire logic        i_compare_ref_half,
  input  wire logic        i_compare_fb_half,
  // VCO controls
  output var  logic        o_cal_start,
  output var  logic        o_cal_auto,
  output var  logic        o_amp_loop_en,
  output var  logic [2:0]  o_amp_threshold,
  output var  logic [5:0]  o_vco_level,
  output var  logic        o_supply_boost,
  output var  logic        o_band_auto,
  output var  logic [6:0]  o_vco_band,
  // Dividers, PLL reset and lock pin
  output var  logic [19:0] o_fb_div,
  output var  logic [1:0]  o_five_six_prescaler,
  output var  logic        o_prescale_invalid,
  output var  logic [10:0] o_first_output_divider,
  output var  logic [10:0] o_second_output_divider,
  output var  logic        o_pll_reset,
  output var  logic        o_lock_pin
);

  logic [7:0]  regs [pvdc_pkg::REG_COUNT];
  logic        in_range;
  logic [3:0]  wr_idx;
  logic [3:0]  rd_idx;
  logic        cal_write;
  logic [19:0] next_fb_div;
  logic [10:0] next_first_div;
  logic [10:0] next_second_div;
  logic [1:0]  next_prescale;
  logic        lock_status;

  // Address decode, shared by read and write
  function automatic logic addr_hit(input logic [7:0] addr);
    addr_hit = (addr >= pvdc_pkg::BASE_ADDR) && (addr <= pvdc_pkg::LAST_ADDR);
  endfunction

  function automatic logic [3:0] addr_index(input logic [7:0] addr);
    logic [7:0] diff;
    diff = addr - pvdc_pkg::BASE_ADDR;
    addr_index = diff[3:0];
  endfunction

  assign in_range = addr_hit(i_addr);
  assign wr_idx   = addr_index(i_addr);
  assign rd_idx   = addr_index(i_addr);

  // Calibration command accepted only with register control set
  assign cal_write = i_wr_en && (i_addr == pvdc_pkg::VCO_CONTROL)
                     && i_wdata[pvdc_pkg::CAL_START_BIT]
                     && i_wdata[pvdc_pkg::CAL_REG_CTL_BIT];

  // Register storage, masked writes
  genvar gi;
  generate
    for (gi = 0; gi < pvdc_pkg::REG_COUNT; gi++) begin : g_reg
      always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
          regs[gi] <= pvdc_pkg::RST_VAL[gi];
        end else if (i_ce) begin
          if (i_wr_en && in_range && (wr_idx == 4'(gi))) begin
            regs[gi] <= i_wdata & pvdc_pkg::WR_MASK[gi];
            if (gi == pvdc_pkg::IDX_VCO_CONTROL) begin
              regs[gi][pvdc_pkg::CAL_START_BIT] <= cal_write;
            end
          end else if (gi == pvdc_pkg::IDX_VCO_CONTROL) begin
            regs[gi][pvdc_pkg::CAL_START_BIT] <= 1'b0;
          end
        end
      end
    end
  endgenerate

  // Read data
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rdata <= 8'h00;
    end else if (i_ce) begin
      o_rdata <= in_range ? regs[rd_idx] : 8'h00;
    end
  end

  // Calibration start pulse, one cycle
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_cal_start <= 1'b0;
    end else if (i_ce) begin
      o_cal_start <= cal_write;
    end else begin
      o_cal_start <= o_cal_start;
    end
  end

  // VCO controls
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_cal_auto      <= !pvdc_pkg::RST_VAL[pvdc_pkg::IDX_VCO_CONTROL]
                         [pvdc_pkg::CAL_REG_CTL_BIT];
      o_amp_loop_en   <= pvdc_pkg::RST_VAL[pvdc_pkg::IDX_VCO_CONTROL]
                         [pvdc_pkg::AMP_LOOP_BIT];
      o_amp_threshold <= pvdc_pkg::RST_VAL[pvdc_pkg::IDX_VCO_CONTROL]
                         [pvdc_pkg::AMP_THR_MSB:pvdc_pkg::AMP_THR_LSB];
      o_vco_level     <= pvdc_pkg::RST_VAL[pvdc_pkg::IDX_VCO_LEVEL]
                         [pvdc_pkg::LEVEL_MSB:pvdc_pkg::LEVEL_LSB];
      o_supply_boost  <= pvdc_pkg::RST_VAL[pvdc_pkg::IDX_VCO_CONTROL]
                         [pvdc_pkg::SUPPLY_BOOST_BIT];
      o_band_auto     <= !pvdc_pkg::RST_VAL[pvdc_pkg::IDX_VCO_CONTROL]
                         [pvdc_pkg::BAND_REG_CTL_BIT];
      o_vco_band      <= pvdc_pkg::RST_VAL[pvdc_pkg::IDX_VCO_BAND]
                         [pvdc_pkg::BAND_MSB:pvdc_pkg::BAND_LSB];
    end else if (i_ce) begin
      o_cal_auto      <= !regs[pvdc_pkg::IDX_VCO_CONTROL][pvdc_pkg::CAL_REG_CTL_BIT];
      o_amp_loop_en   <= regs[pvdc_pkg::IDX_VCO_CONTROL][pvdc_pkg::AMP_LOOP_BIT];
      o_amp_threshold <= regs[pvdc_pkg::IDX_VCO_CONTROL]
                         [pvdc_pkg::AMP_THR_MSB:pvdc_pkg::AMP_THR_LSB];
      o_vco_level     <= regs[pvdc_pkg::IDX_VCO_LEVEL]
                         [pvdc_pkg::LEVEL_MSB:pvdc_pkg::LEVEL_LSB];
      o_supply_boost  <= regs[pvdc_pkg::IDX_VCO_CONTROL][pvdc_pkg::SUPPLY_BOOST_BIT];
      o_band_auto     <= !regs[pvdc_pkg::IDX_VCO_CONTROL][pvdc_pkg::BAND_REG_CTL_BIT];
      o_vco_band      <= regs[pvdc_pkg::IDX_VCO_BAND]
                         [pvdc_pkg::BAND_MSB:pvdc_pkg::BAND_LSB];
    end
  end

  // Effective divider values: pins or registers
  always_comb begin
    if (regs[pvdc_pkg::IDX_FB_LOW_CTRL][pvdc_pkg::FB_REG_CTL_BIT]) begin
      next_fb_div = {regs[pvdc_pkg::IDX_FB_HIGH], regs[pvdc_pkg::IDX_FB_MID],
                     regs[pvdc_pkg::IDX_FB_LOW_CTRL]
                     [pvdc_pkg::FB_NIB_MSB:pvdc_pkg::FB_NIB_LSB]};
    end else begin
      next_fb_div = i_pin_fb_div;
    end
    if (regs[pvdc_pkg::IDX_FB_LOW_CTRL][pvdc_pkg::OUT_REG_CTL_BIT]) begin
      next_first_div  = {1'b0, regs[pvdc_pkg::IDX_P1_HIGH],
                         regs[pvdc_pkg::IDX_DIV_SPLIT]
                         [pvdc_pkg::P1_LOW_MSB:pvdc_pkg::P1_LOW_LSB]};
      next_second_div = {1'b0, regs[pvdc_pkg::IDX_DIV_SPLIT]
                         [pvdc_pkg::P2_HIGH_MSB:pvdc_pkg::P2_HIGH_LSB],
                         regs[pvdc_pkg::IDX_P2_TEST]
                         [pvdc_pkg::P2_LOW_MSB:pvdc_pkg::P2_LOW_LSB]};
      next_prescale   = regs[pvdc_pkg::IDX_PRESCALE]
                        [pvdc_pkg::PRE_MSB:pvdc_pkg::PRE_LSB];
    end else begin
      next_first_div  = i_pin_first_div;
      next_second_div = i_pin_second_div;
      next_prescale   = i_pin_prescale;
    end
  end

  // Divider outputs
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_fb_div                <= 20'h00000;
      o_first_output_divider  <= 11'h000;
      o_second_output_divider <= 11'h000;
      o_five_six_prescaler    <= 2'h0;
      o_prescale_invalid      <= 1'b0;
    end else if (i_ce) begin
      o_fb_div                <= next_fb_div;
      o_first_output_divider  <= next_first_div;
      o_second_output_divider <= next_second_div;
      o_five_six_prescaler    <= next_prescale;
      o_prescale_invalid      <= (next_prescale != pvdc_pkg::PRE_DIV5)
                                 && (next_prescale != pvdc_pkg::PRE_DIV6);
    end
  end

  // PLL logic reset; output dividers are unaffected
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_pll_reset <= 1'b0;
    end else if (i_ce) begin
      o_pll_reset <= regs[pvdc_pkg::IDX_FB_LOW_CTRL][pvdc_pkg::PLL_RESET_BIT];
    end
  end

  // Lock status gated by detector power-down
  assign lock_status = i_pll_locked && !i_lock_det_pd;

  pvdc_lock_pin_mux u_lock_pin (
    .i_clk                (i_clk),
    .i_rst_n              (i_rst_n),
    .i_ce                 (i_ce),
    .i_test_en            (regs[pvdc_pkg::IDX_P2_TEST][pvdc_pkg::TEST_EN_BIT]),
    .i_test_sel           (regs[pvdc_pkg::IDX_P2_TEST]
                           [pvdc_pkg::TEST_SEL_MSB:pvdc_pkg::TEST_SEL_LSB]),
    .i_lock_status        (lock_status),
    .i_crystal_osc_output (i_crystal_osc_output),
    .i_pump_up_half       (i_pump_up_half),
    .i_compare_ref_half   (i_compare_ref_half),
    .i_compare_fb_half    (i_compare_fb_half),
    .o_lock_pin           (o_lock_pin)
  );

endmodule // pvdc_regs

`default_nettype wire

// ---- pvdc_regs_monitor.sv ----
// Port checker for the PLL, VCO and divider control register bank
`timescale 1ns/1ps
`default_nettype none

module pvdc_regs_monitor (
  input wire logic        i_clk,
  input wire logic        i_rst_n,
  input wire logic        i_ce,
  input wire logic        i_wr_en,
  input wire logic [7:0]  i_addr,
  input wire logic [7:0]  i_wdata,
  input wire logic [19:0] i_pin_fb_div,
  input wire logic        i_lock_det_pd,
  input wire logic        i_pll_locked,
  input wire logic [7:0]  o_rdata,
  input wire logic        o_cal_start,
  input wire logic        o_cal_auto,
  input wire logic [19:0] o_fb_div,
  input wire logic        o_pll_reset,
  input wire logic        o_lock_pin
);
  logic test_q;
  logic fbc_q;
  wire  wr_ok = i_ce && i_wr_en;
  wire  wcal  = wr_ok && i_addr == 8'h0e && i_wdata[7] && i_wdata[2];

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_n);

  // Mirror of test port enable
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n)
      test_q <= 1'b0;
    else if (wr_ok && i_addr == 8'h17)
      test_q <= i_wdata[3];
  end

  // Mirror of feedback register control
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n)
      fbc_q <= 1'b0;
    else if (wr_ok && i_addr == 8'h14)
      fbc_q <= i_wdata[3];
  end

  AST_CAL_CAUSE: assert property ($rose(o_cal_start) |-> $past(wcal))
    else $error("calibration pulse without enabled request");
  AST_CAL_IDLE: assert property (!$past(wcal) && !$past(wcal, 2) |-> !o_cal_start)
    else $error("calibration pulse stands too long");
  AST_CAL_MODE: assert property (wr_ok && i_addr == 8'h0e |-> ##2 o_cal_auto == !$past(i_wdata[2], 2))
    else $error("calibration mode not from written enable");
  AST_PLL_RST: assert property (wr_ok && i_addr == 8'h14 |-> ##2 o_pll_reset == $past(i_wdata[0], 2))
    else $error("pll reset not from written bit");
  AST_LOCK_STATUS: assert property (i_ce && !test_q |=> o_lock_pin == $past(i_pll_locked && !i_lock_det_pd))
    else $error("lock pin does not follow lock status");
  AST_FB_PINS: assert property (i_ce && !fbc_q |=> o_fb_div == $past(i_pin_fb_div))
    else $error("feedback divider not from pins");
  AST_RD_OUTSIDE: assert property (i_ce && (i_addr < 8'h0e || i_addr > 8'h19) |=> o_rdata == 8'h00)
    else $error("read outside window not zero");
  AST_RD_PRESCALE: assert property (i_ce && i_addr == 8'h18 |=> (o_rdata & 8'h9f) == 8'h00)
    else $error("unused prescaler bits not zero");
endmodule // pvdc_regs_monitor

bind pvdc_regs pvdc_regs_monitor i_mon (
  .i_clk, .i_rst_n, .i_ce, .i_wr_en, .i_addr, .i_wdata, .i_pin_fb_div, .i_lock_det_pd,
  .i_pll_locked, .o_rdata, .o_cal_start, .o_cal_auto, .o_fb_div, .o_pll_reset, .o_lock_pin
);
`default_nettype wire

// ---- pvdc_regs_tb.sv ----
// Self-checking bench for the control register bank
`timescale 1ns/1ps
`default_nettype none

module pvdc_regs_tb;
  logic        i_clk = 1'b0;
  logic        i_rst_n = 1'b0;
  logic        i_ce = 1'b1;
  logic        i_wr_en;
  logic [7:0]  i_addr, i_wdata, o_rdata, rv;
  logic [19:0] i_pin_fb_div = 20'h12345;
  logic [1:0]  i_pin_prescale = 2'h2;
  logic [10:0] i_pin_first_div = 11'h5a5;
  logic [10:0] i_pin_second_div = 11'h2c3;
  logic        i_lock_det_pd = 1'b0;
  logic        i_pll_locked = 1'b1;
  logic [3:0]  src = 4'h6;
  logic        o_cal_start, o_cal_auto, o_amp_loop_en, o_supply_boost, o_band_auto;
  logic        o_prescale_invalid, o_pll_reset, o_lock_pin;
  logic [2:0]  o_amp_threshold;
  logic [5:0]  o_vco_level;
  logic [6:0]  o_vco_band;
  logic [19:0] o_fb_div;
  logic [1:0]  o_five_six_prescaler;
  logic [10:0] o_first_output_divider, o_second_output_divider;
  int          num_errors = 0;
  int          n_compared = 0;
  int          n;
  logic [7:0]  rst_exp [12] = '{8'h70, 8'h80, 8'h80, 8'h00, 8'h80, 8'h00,
                                8'h00, 8'h20, 8'h00, 8'h00, 8'h20, 8'h00};
  logic [7:0]  one_exp [14] = '{8'h00, 8'h7f, 8'hfc, 8'hfe, 8'h00, 8'hff, 8'hff,
                                8'hfd, 8'hff, 8'hff, 8'hfe, 8'h60, 8'h00, 8'h00};

  pvdc_host_model h (.i_clk, .i_rdata(o_rdata), .o_wr_en(i_wr_en), .o_addr(i_addr),
                     .o_wdata(i_wdata));

  pvdc_regs i_dut (.i_clk, .i_rst_n, .i_ce, .i_wr_en, .i_addr, .i_wdata, .o_rdata,
    .i_pin_fb_div, .i_pin_prescale, .i_pin_first_div, .i_pin_second_div, .i_lock_det_pd,
    .i_pll_locked, .i_crystal_osc_output(src[0]), .i_pump_up_half(src[1]),
    .i_compare_ref_half(src[2]), .i_compare_fb_half(src[3]), .o_cal_start, .o_cal_auto,
    .o_amp_loop_en, .o_amp_threshold, .o_vco_level, .o_supply_boost, .o_band_auto,
    .o_vco_band, .o_fb_div, .o_five_six_prescaler, .o_prescale_invalid,
    .o_first_output_divider, .o_second_output_divider, .o_pll_reset, .o_lock_pin);

  initial begin
    forever #4 i_clk = ~i_clk;
  end

  task automatic chk(input logic [19:0] g, input logic [19:0] e);
    n_compared++;
    if (g !== e) begin
      num_errors++;
      $display("BAD %0t got %h expected %h", $time, g, e);
    end
  endtask

  // Counts calibration pulses over the following cycles
  task automatic cal_cnt(output int c);
    c = 0;
    repeat (3) begin
      c += (o_cal_start === 1'b1);
      @(negedge i_clk);
    end
  endtask

  task automatic print_verdict();
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  initial begin
    #40000;
    num_errors++;
    print_verdict();
  end

  initial begin
    repeat (4) @(negedge i_clk);
    i_rst_n = 1'b1;
    @(negedge i_clk);
    chk(o_amp_loop_en, 1'b1);
    chk(o_amp_threshold, 3'h6);
    chk(o_vco_level, 6'h20);
    chk({o_band_auto, o_vco_band}, 8'hc0);
    chk({o_cal_auto, o_supply_boost}, 2'h2);
    chk(o_fb_div, i_pin_fb_div);
    chk({o_five_six_prescaler, o_first_output_divider}, {2'h2, 11'h5a5});
    chk(o_second_output_divider, i_pin_second_div);
    chk(o_lock_pin, 1'b1);
    for (int i = 0; i < 12; i++) begin
      h.rd(8'h0e + 8'(i), rv);
      chk(rv, rst_exp[i]);
    end
    h.wr(8'h14, 8'h0c);
    @(negedge i_clk);
    chk(o_fb_div, 20'h80000);
    chk(o_first_output_divider, 11'd128);
    $display("test reset values done");
    for (int i = 0; i < 14; i++) h.wr(8'h0d + 8'(i), 8'hff);
    @(negedge i_clk);
    chk({o_vco_level, o_supply_boost, o_band_auto}, 8'hfe);
    chk({o_vco_band, o_cal_auto}, 8'hfe);
    chk({o_amp_loop_en, o_amp_threshold}, 4'hf);
    chk(o_fb_div, 20'hfffff);
    chk({o_five_six_prescaler, o_prescale_invalid}, 3'h7);
    chk({o_first_output_divider, o_pll_reset}, 12'h7ff);
    chk(o_second_output_divider, 11'h3ff);
    for (int i = 0; i < 14; i++) begin
      h.rd(8'h0d + 8'(i), rv);
      chk(rv, one_exp[i]);
    end
    for (int c = 0; c < 4; c++) begin
      h.wr(8'h18, {1'b0, 2'(c), 5'h1f});
      @(negedge i_clk);
      chk({o_five_six_prescaler, o_prescale_invalid}, {2'(c), c == 0 || c == 3});
    end
    h.wr(8'h15, 8'h5a);
    h.wr(8'h16, 8'h9c);
    h.wr(8'h17, 8'hb0);
    h.wr(8'h14, 8'h3c);
    @(negedge i_clk);
    chk(o_first_output_divider, 11'h16a);
    chk(o_second_output_divider, 11'h1cb);
    chk({o_fb_div, o_pll_reset}, {20'hffff3, 1'b0});
    $display("test register values done");
    h.wr(8'h0e, 8'h84);
    cal_cnt(n);
    chk(20'(n), 20'h1);
    chk({o_amp_loop_en, o_amp_threshold, o_band_auto}, 5'h01);
    h.rd(8'h0e, rv);
    chk(rv, 8'h04);
    h.wr(8'h0e, 8'h80);
    cal_cnt(n);
    chk(20'(n), 20'h0);
    chk(o_cal_auto, 1'b1);
    i_ce = 1'b0;
    h.wr(8'h0e, 8'hc4);
    cal_cnt(n);
    chk(20'(n), 20'h0);
    chk(o_cal_auto, 1'b1);
    i_ce = 1'b1;
    h.rd(8'h0e, rv);
    chk(rv, 8'h00);
    $display("test calibration done");
    for (int p = 0; p < 2; p++) begin
      src = p ? 4'h9 : 4'h6;
      for (int s = 0; s < 4; s++) begin
        h.wr(8'h17, {4'h0, 1'b1, 2'(s), 1'b0});
        @(negedge i_clk);
        chk(o_lock_pin, src[s]);
      end
    end
    h.wr(8'h17, 8'h00);
    i_lock_det_pd = 1'b1;
    repeat (2) @(negedge i_clk);
    chk(o_lock_pin, 1'b0);
    i_lock_det_pd = 1'b0;
    repeat (2) @(negedge i_clk);
    chk(o_lock_pin, 1'b1);
    h.wr(8'h14, 8'h00);
    @(negedge i_clk);
    chk(o_fb_div, i_pin_fb_div);
    chk({o_five_six_prescaler, o_second_output_divider}, {2'h2, 11'h2c3});
    $display("test lock pin and pin mode done");
    print_verdict();
  end
endmodule // pvdc_regs_tb
`default_nettype wire
